// >>> inc/parallel_port_data_pin_mux_defs.svh
// Offsets, field positions, reset values and widths of the data pin multiplexer
`ifndef PARALLEL_PORT_DATA_PIN_MUX_DEFS_SVH
`define PARALLEL_PORT_DATA_PIN_MUX_DEFS_SVH

`define PPD_ADDR_W          5
`define PPD_DATA_W          32
`define PPD_HALF_W          16
`define PPD_CLK_OUTS        2

`define PPD_OFS_BUS_CTRL    5'h00
`define PPD_OFS_GCTRL_A     5'h04
`define PPD_OFS_GCTRL_B     5'h08
`define PPD_OFS_GP_DIR      5'h0c
`define PPD_OFS_GP_OUT      5'h10
`define PPD_OFS_GP_IN       5'h14
`define PPD_OFS_STATUS      5'h18

`define PPD_BIT_HOLDER_UP   0
`define PPD_BIT_HOLDER_LO   1
`define PPD_BIT_CLK_FLOAT   0
`define PPD_BIT_ST_FUNC     0
`define PPD_BIT_ST_HOLD     1
`define PPD_BIT_ST_OFF      2

`define PPD_RST_BUS_CTRL    2'h3
`define PPD_RST_CLK_FLOAT   1'h0
`define PPD_RST_GP_DIR      16'h0000
`define PPD_RST_GP_OUT      16'h0000

`endif

// >>> inc/parallel_port_data_pin_mux_pkg.sv
// Types shared by the data pin multiplexer files
package parallel_port_data_pin_mux_pkg;

  typedef enum logic [0:0] {
    FUNC_GPIO   = 1'b0,
    FUNC_EXTMEM = 1'b1
  } pin_func_e;

  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } pin_drive_s;

  typedef struct packed {
    logic function_select_strap;
    logic hold_req_n;
    logic trst_n;
    logic emulation_pin_first;
    logic emulation_pin_second_shutdown;
  } ctrl_pins_s;

endpackage

// >>> logic/pin_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // Only the second stage is read outside this module
  always_ff @(posedge clk) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // pin_sync

// >>> logic/bus_keeper.sv
// Bus holder for one group of data pins: remembers the last driven level
`timescale 1ns/100ps
module bus_keeper #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] pad_out,
  input  wire logic [WIDTH-1:0] pad_oe,
  output      logic [WIDTH-1:0] keep_val,
  output      logic [WIDTH-1:0] keep_en
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Track the level only while the pad is actively driven
      always_ff @(posedge clk) begin
        if (rst) begin
          keep_val[i] <= 1'b0;
        end else if (pad_oe[i]) begin
          keep_val[i] <= pad_out[i];
        end
      end
      // Weak keeper acts only when nobody drives the pad
      assign keep_en[i] = enable & ~pad_oe[i];
    end
  endgenerate

endmodule // bus_keeper

// >>> logic/parallel_port_data_pin_mux.sv
// Pin multiplexer and pad-state control for the 32 parallel port data pins
`timescale 1ns/100ps
`include "parallel_port_data_pin_mux_defs.svh"
module parallel_port_data_pin_mux (
  input  wire logic                        MCLK,
  input  wire logic                        SYS_RST,
  input  wire logic [`PPD_ADDR_W-1:0]      AVS_ADDRESS,
  input  wire logic                        AVS_READ,
  input  wire logic                        AVS_WRITE,
  input  wire logic [`PPD_DATA_W-1:0]      AVS_WRITEDATA,
  output      logic [`PPD_DATA_W-1:0]      AVS_READDATA,
  output      logic                        AVS_WAITREQUEST,
  input  wire logic                        FUNCTION_SELECT_STRAP,
  input  wire logic                        HOLD_REQ_N,
  input  wire logic                        TRST_N,
  input  wire logic                        EMULATION_PIN_FIRST,
  input  wire logic                        EMULATION_PIN_SECOND_SHUTDOWN,
  input  wire logic [`PPD_DATA_W-1:0]      D_IN,
  output      logic [`PPD_DATA_W-1:0]      D_OUT,
  output      logic [`PPD_DATA_W-1:0]      D_OE,
  output      logic [`PPD_DATA_W-1:0]      D_KEEP_VAL,
  output      logic [`PPD_DATA_W-1:0]      D_KEEP_EN,
  input  wire logic [`PPD_DATA_W-1:0]      EXT_MEM_IF_WDATA,
  input  wire logic                        EXT_MEM_IF_DRIVE,
  output      logic [`PPD_DATA_W-1:0]      EXT_MEM_IF_RDATA,
  output      logic [`PPD_CLK_OUTS-1:0]    EXT_MEM_CLK_OUT,
  output      logic [`PPD_CLK_OUTS-1:0]    EXT_MEM_CLK_OE,
  output      logic                        FUNC_EXT_MEM,
  output      logic                        HOLD_ACTIVE,
  output      logic                        OFF_ACTIVE
);

  parallel_port_data_pin_mux_pkg::ctrl_pins_s ctrl_raw;
  parallel_port_data_pin_mux_pkg::ctrl_pins_s ctrl_s;
  parallel_port_data_pin_mux_pkg::pin_func_e  func_sel;
  parallel_port_data_pin_mux_pkg::pin_drive_s next_drive;
  parallel_port_data_pin_mux_pkg::pin_drive_s drive;

  logic [`PPD_DATA_W-1:0]   d_in_s;
  logic                     hold_mode;
  logic                     off_mode;
  logic [1:0]               ext_bus_ctrl_reg;
  logic [`PPD_CLK_OUTS-1:0] clkout_hold_float;
  logic [`PPD_HALF_W-1:0]   gp_dir;
  logic [`PPD_HALF_W-1:0]   gp_out;
  logic [`PPD_HALF_W-1:0]   gp_in;
  logic [2:0]               status;
  logic                     ack;
  logic                     wr_fire;
  logic                     rd_load;
  logic [`PPD_DATA_W-1:0]   next_readdata;
  logic                     clk_phase;

  // Pins from the board are synchronised before any logic looks at them
  assign ctrl_raw.function_select_strap         = FUNCTION_SELECT_STRAP;
  assign ctrl_raw.hold_req_n                    = HOLD_REQ_N;
  assign ctrl_raw.trst_n                        = TRST_N;
  assign ctrl_raw.emulation_pin_first           = EMULATION_PIN_FIRST;
  assign ctrl_raw.emulation_pin_second_shutdown = EMULATION_PIN_SECOND_SHUTDOWN;

  pin_sync #(
    .WIDTH    ($bits(ctrl_raw))
  ) u_ctrl_sync (
    .clk      (MCLK),
    .rst      (1'b0),
    .async_in (ctrl_raw),
    .sync_out (ctrl_s)
  );

  pin_sync #(
    .WIDTH    (`PPD_DATA_W)
  ) u_data_sync (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .async_in (D_IN),
    .sync_out (d_in_s)
  );

  // Strap is tracked through the whole reset; the last sample before release is kept.
  // The control synchroniser is not reset so the strap is valid while reset is held.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      if (ctrl_s.function_select_strap) begin
        func_sel <= parallel_port_data_pin_mux_pkg::FUNC_EXTMEM;
      end else begin
        func_sel <= parallel_port_data_pin_mux_pkg::FUNC_GPIO;
      end
    end // Outside reset the selection is frozen
  end

  assign hold_mode = ~ctrl_s.hold_req_n;
  assign off_mode  = ~ctrl_s.trst_n & ctrl_s.emulation_pin_first
                   & ~ctrl_s.emulation_pin_second_shutdown;

  // Avalon slave: one wait cycle per access, then the answer
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
  assign wr_fire         = AVS_WRITE & ack;
  assign rd_load         = AVS_READ & ~ack;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ | AVS_WRITE) & ~ack;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ext_bus_ctrl_reg <= `PPD_RST_BUS_CTRL;
    end else if (wr_fire && AVS_ADDRESS == `PPD_OFS_BUS_CTRL) begin
      ext_bus_ctrl_reg <= AVS_WRITEDATA[1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      clkout_hold_float <= {`PPD_CLK_OUTS{`PPD_RST_CLK_FLOAT}};
    end else if (wr_fire && AVS_ADDRESS == `PPD_OFS_GCTRL_A) begin
      clkout_hold_float[0] <= AVS_WRITEDATA[`PPD_BIT_CLK_FLOAT];
    end else if (wr_fire && AVS_ADDRESS == `PPD_OFS_GCTRL_B) begin
      clkout_hold_float[1] <= AVS_WRITEDATA[`PPD_BIT_CLK_FLOAT];
    end
  end

  // Direction reset to all inputs; in memory mode these bits have no effect
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      gp_dir <= `PPD_RST_GP_DIR;
    end else if (wr_fire && AVS_ADDRESS == `PPD_OFS_GP_DIR) begin
      gp_dir <= AVS_WRITEDATA[`PPD_HALF_W-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      gp_out <= `PPD_RST_GP_OUT;
    end else if (wr_fire && AVS_ADDRESS == `PPD_OFS_GP_OUT) begin
      gp_out <= AVS_WRITEDATA[`PPD_HALF_W-1:0];
    end
  end

  // Input view of the upper pins; reads zero in memory mode
  assign gp_in = (func_sel == parallel_port_data_pin_mux_pkg::FUNC_GPIO) ?
                 d_in_s[`PPD_DATA_W-1:`PPD_HALF_W] : '0;

  assign status = {off_mode, hold_mode, func_sel == parallel_port_data_pin_mux_pkg::FUNC_EXTMEM};

  always_comb begin
    next_readdata = '0;
    unique case (AVS_ADDRESS)
      `PPD_OFS_BUS_CTRL: next_readdata[1:0]                 = ext_bus_ctrl_reg;
      `PPD_OFS_GCTRL_A:  next_readdata[`PPD_BIT_CLK_FLOAT]  = clkout_hold_float[0];
      `PPD_OFS_GCTRL_B:  next_readdata[`PPD_BIT_CLK_FLOAT]  = clkout_hold_float[1];
      `PPD_OFS_GP_DIR:   next_readdata[`PPD_HALF_W-1:0]     = gp_dir;
      `PPD_OFS_GP_OUT:   next_readdata[`PPD_HALF_W-1:0]     = gp_out;
      `PPD_OFS_GP_IN:    next_readdata[`PPD_HALF_W-1:0]     = gp_in;
      `PPD_OFS_STATUS:   next_readdata[2:0]                 = status;
      default:           next_readdata                      = '0;
    endcase
  end

  // Read data is sampled in the wait cycle so it is stable when waitrequest drops
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      AVS_READDATA <= '0;
    end else if (rd_load) begin
      AVS_READDATA <= next_readdata;
    end
  end

  // Pad drive selection; float conditions override every function
  always_comb begin
    next_drive.out = '0;
    next_drive.oe  = '0;
    unique case (func_sel)
      parallel_port_data_pin_mux_pkg::FUNC_GPIO: begin
        next_drive.out[`PPD_DATA_W-1:`PPD_HALF_W] = gp_out;
        next_drive.oe[`PPD_DATA_W-1:`PPD_HALF_W]  = gp_dir;
        next_drive.out[`PPD_HALF_W-1:0]           = '0;
        next_drive.oe[`PPD_HALF_W-1:0]            = '0;
      end
      parallel_port_data_pin_mux_pkg::FUNC_EXTMEM: begin
        // The memory controller keeps its drive low after reset
        next_drive.out = EXT_MEM_IF_WDATA;
        next_drive.oe  = {`PPD_DATA_W{EXT_MEM_IF_DRIVE}};
      end
    endcase
    if (hold_mode) begin
      next_drive.oe = '0;
    end
    if (off_mode) begin
      next_drive.oe = '0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  assign D_OUT = drive.out;
  assign D_OE  = drive.oe;

  // All 32 pins reach the memory data path in memory mode only; it reads zero in GP mode
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      EXT_MEM_IF_RDATA <= '0;
    end else if (func_sel == parallel_port_data_pin_mux_pkg::FUNC_EXTMEM) begin
      EXT_MEM_IF_RDATA <= d_in_s;
    end else begin
      EXT_MEM_IF_RDATA <= '0;
    end
  end

  bus_keeper #(
    .WIDTH    (`PPD_HALF_W)
  ) u_keep_upper (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .enable   (ext_bus_ctrl_reg[`PPD_BIT_HOLDER_UP]),
    .pad_out  (drive.out[`PPD_DATA_W-1:`PPD_HALF_W]),
    .pad_oe   (drive.oe[`PPD_DATA_W-1:`PPD_HALF_W]),
    .keep_val (D_KEEP_VAL[`PPD_DATA_W-1:`PPD_HALF_W]),
    .keep_en  (D_KEEP_EN[`PPD_DATA_W-1:`PPD_HALF_W])
  );

  bus_keeper #(
    .WIDTH    (`PPD_HALF_W)
  ) u_keep_lower (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .enable   (ext_bus_ctrl_reg[`PPD_BIT_HOLDER_LO]),
    .pad_out  (drive.out[`PPD_HALF_W-1:0]),
    .pad_oe   (drive.oe[`PPD_HALF_W-1:0]),
    .keep_val (D_KEEP_VAL[`PPD_HALF_W-1:0]),
    .keep_en  (D_KEEP_EN[`PPD_HALF_W-1:0])
  );

  // Memory clocks run at half MCLK; they keep running in hold unless floated
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      clk_phase <= 1'b0;
    end else begin
      clk_phase <= ~clk_phase;
    end
  end

  genvar c;
  generate
    for (c = 0; c < `PPD_CLK_OUTS; c++) begin : g_clkout
      always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
          EXT_MEM_CLK_OUT[c] <= 1'b0;
          EXT_MEM_CLK_OE[c]  <= 1'b0;
        end else begin
          EXT_MEM_CLK_OUT[c] <= clk_phase;
          EXT_MEM_CLK_OE[c]  <= ~(hold_mode & clkout_hold_float[c]);
        end
      end
    end
  endgenerate

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      HOLD_ACTIVE <= 1'b0;
      OFF_ACTIVE  <= 1'b0;
    end else begin
      HOLD_ACTIVE <= hold_mode;
      OFF_ACTIVE  <= off_mode;
    end
  end

  assign FUNC_EXT_MEM = (func_sel == parallel_port_data_pin_mux_pkg::FUNC_EXTMEM);

endmodule // parallel_port_data_pin_mux

// >>> dv/parallel_port_data_pin_mux_properties.sv
// Port checks for the data pin multiplexer
`timescale 1ns/100ps
module ppd_props (
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [31:0] D_OUT,
  input wire logic [31:0] D_OE,
  input wire logic [31:0] D_KEEP_VAL,
  input wire logic [31:0] EXT_MEM_IF_WDATA,
  input wire logic        EXT_MEM_IF_DRIVE,
  input wire logic [31:0] EXT_MEM_IF_RDATA,
  input wire logic [1:0]  EXT_MEM_CLK_OUT,
  input wire logic [1:0]  EXT_MEM_CLK_OE,
  input wire logic        FUNC_EXT_MEM,
  input wire logic        HOLD_ACTIVE,
  input wire logic        OFF_ACTIVE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Reset itself is the cause here, so this one stays armed through it
  a_reset_float: assert property (disable iff (1'b0) SYS_RST |=> D_OE == 32'h0)
    else $error("pins driven in reset");
  a_hold_float: assert property (HOLD_ACTIVE |-> D_OE == 32'h0)
    else $error("pins driven in hold");
  a_off_float: assert property (OFF_ACTIVE |-> D_OE == 32'h0)
    else $error("pins driven in off mode");
  a_clk_keeps_toggling: assert property ((EXT_MEM_CLK_OE & $past(EXT_MEM_CLK_OE)
    & (EXT_MEM_CLK_OUT ~^ $past(EXT_MEM_CLK_OUT))) == 2'h0)
    else $error("driven clock stopped");
  a_lower_never_driven: assert property (!FUNC_EXT_MEM |-> D_OE[15:0] == 16'h0)
    else $error("reserved pins driven");
  a_gp_rdata_zero: assert property (!FUNC_EXT_MEM |-> EXT_MEM_IF_RDATA == 32'h0)
    else $error("pin input leaks in gp mode");
  a_func_held: assert property (!$past(SYS_RST) |-> $stable(FUNC_EXT_MEM))
    else $error("function changed outside reset");
  a_mem_data_out: assert property (FUNC_EXT_MEM && EXT_MEM_IF_DRIVE
    |=> D_OUT == $past(EXT_MEM_IF_WDATA))
    else $error("memory data not on pins");
  a_keeper_last: assert property (|($past(D_OE) & ~D_OE)
    |-> ((D_KEEP_VAL ^ $past(D_OUT)) & $past(D_OE) & ~D_OE) == 32'h0)
    else $error("holder lost last level");
  a_wait_one: assert property ($rose(AVS_READ || AVS_WRITE)
    |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("register access not one wait");
endmodule // ppd_props

bind parallel_port_data_pin_mux ppd_props u_props (.MCLK, .SYS_RST, .AVS_READ, .AVS_WRITE,
  .AVS_WAITREQUEST, .D_OUT, .D_OE, .D_KEEP_VAL, .EXT_MEM_IF_WDATA, .EXT_MEM_IF_DRIVE,
  .EXT_MEM_IF_RDATA, .EXT_MEM_CLK_OUT, .EXT_MEM_CLK_OE, .FUNC_EXT_MEM, .HOLD_ACTIVE,
  .OFF_ACTIVE);

// >>> dv/pad_partner.sv
// Far side of the data pins: resolves each wire and feeds it back
`timescale 1ns/100ps
module pad_partner (
  input  wire logic        clk,
  input  wire logic [31:0] d_out,
  input  wire logic [31:0] d_oe,
  input  wire logic [31:0] keep_val,
  input  wire logic [31:0] keep_en,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output      logic [31:0] d_in
);
  logic [31:0] junk = 32'h0;
  // A floating wire wanders every cycle so that reading it cannot pass by luck
  always @(posedge clk) junk <= ~junk;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      // A board driver beats the weak holder
      d_in[i] = d_oe[i] ? d_out[i] : ext_en[i] ? ext_val[i] : keep_en[i] ? keep_val[i] : junk[i];
    end
  end
endmodule // pad_partner

// >>> dv/tb_parallel_port_data_pin_mux.sv
// Self-checking bench for the data pin multiplexer
`timescale 1ns/100ps
module tb_parallel_port_data_pin_mux;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        strap = 1'b0;
  logic        hold_n = 1'b1;
  logic        trst_n = 1'b1;
  logic        emu_a = 1'b0;
  logic        emu_b = 1'b1;
  logic [31:0] mem_wdata = 32'h0;
  logic        mem_drive = 1'b0;
  logic [31:0] ext_en = 32'h0;
  logic [31:0] ext_val = 32'h0;
  logic [31:0] rdata, d_in, d_out, d_oe, keep_val, keep_en, mem_rdata, q;
  logic [1:0]  clk_out, clk_oe;
  logic        waitreq, func, hold_act, off_act;
  int          fails = 0;
  int          n_tests = 0;
  int          cycles = 0;

  always #25 mclk = ~mclk;

  parallel_port_data_pin_mux uut (.MCLK(mclk), .SYS_RST(sys_rst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .FUNCTION_SELECT_STRAP(strap), .HOLD_REQ_N(hold_n),
    .TRST_N(trst_n), .EMULATION_PIN_FIRST(emu_a), .EMULATION_PIN_SECOND_SHUTDOWN(emu_b),
    .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .D_KEEP_VAL(keep_val), .D_KEEP_EN(keep_en),
    .EXT_MEM_IF_WDATA(mem_wdata), .EXT_MEM_IF_DRIVE(mem_drive), .EXT_MEM_IF_RDATA(mem_rdata),
    .EXT_MEM_CLK_OUT(clk_out), .EXT_MEM_CLK_OE(clk_oe), .FUNC_EXT_MEM(func),
    .HOLD_ACTIVE(hold_act), .OFF_ACTIVE(off_act));
  pad_partner far_end (.clk(mclk), .d_out(d_out), .d_oe(d_oe), .keep_val(keep_val),
    .keep_en(keep_en), .ext_en(ext_en), .ext_val(ext_val), .d_in(d_in));

  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Looks land mid-cycle, where registered and combinational outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Request held until the rising edge that sees waitrequest low; data taken at that edge
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wr    <= w;
    rd    <= ~w;
    wdata <= d;
    do @(posedge mclk); while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input string what);
    av(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask

  task automatic boot(input logic s);
    @(posedge mclk);
    sys_rst <= 1'b1;
    strap   <= s;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(d_oe, 32'h0, "oe in reset");
    chk(keep_en, 32'hffff_ffff, "holders in reset");
    @(posedge mclk);
    sys_rst <= 1'b0;
    cyc(2);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      results;
    end
  end

  initial begin
    boot(1'b0);
    chk(func, 1'b0, "function gp");
    chk(d_oe, 32'h0, "oe after reset");
    rchk(5'h00, 32'h3, "bus ctrl");
    rchk(5'h0c, 32'h0, "gp dir");
    rchk(5'h1c, 32'h0, "unmapped");
    @(posedge mclk);
    ext_en  <= 32'hffff_ffff;
    ext_val <= 32'ha5c3_5a5a;
    cyc(4);
    rchk(5'h14, 32'ha5c3, "gp input");
    chk(mem_rdata, 32'h0, "rdata gp");
    @(posedge mclk);
    ext_en <= 32'h0;
    av(1'b1, 5'h0c, 32'h00f0);
    av(1'b1, 5'h10, 32'h0030);
    cyc(2);
    chk(d_oe, 32'h00f0_0000, "gp oe");
    chk(d_out & 32'h00f0_0000, 32'h0030_0000, "gp out");
    av(1'b1, 5'h0c, 32'h0);
    cyc(2);
    chk(keep_val & 32'h00f0_0000, 32'h0030_0000, "keep val");
    chk(keep_en, 32'hffff_ffff, "keep en");
    av(1'b1, 5'h00, 32'h0);
    cyc(2);
    chk(keep_en, 32'h0, "keep off");
    av(1'b1, 5'h00, 32'h3);
    av(1'b1, 5'h0c, 32'hffff);
    @(posedge mclk);
    hold_n <= 1'b0;
    cyc(5);
    chk(hold_act, 1'b1, "hold");
    chk(d_oe, 32'h0, "oe hold");
    chk(clk_oe, 2'h3, "clk oe hold");
    q = clk_out;
    cyc(1);
    chk(clk_out, ~q & 32'h3, "clk toggles in hold");
    @(posedge mclk);
    hold_n <= 1'b1;
    trst_n <= 1'b0;
    emu_a  <= 1'b1;
    emu_b  <= 1'b0;
    cyc(5);
    chk(off_act, 1'b1, "off");
    chk(d_oe, 32'h0, "oe off");
    @(posedge mclk);
    trst_n <= 1'b1;
    strap  <= 1'b1;
    cyc(5);
    chk(d_oe, 32'hffff_0000, "gp oe all");
    chk(func, 1'b0, "function held");
    boot(1'b1);
    chk(func, 1'b1, "function mem");
    chk(d_oe, 32'h0, "oe mem reset");
    rchk(5'h18, 32'h1, "status");
    av(1'b1, 5'h0c, 32'hffff);
    @(posedge mclk);
    ext_en  <= 32'hffff_ffff;
    ext_val <= 32'h1234_abcd;
    cyc(4);
    chk(d_oe, 32'h0, "gp dir ignored");
    chk(mem_rdata, 32'h1234_abcd, "mem rdata");
    rchk(5'h14, 32'h0, "gp input mem");
    @(posedge mclk);
    ext_en    <= 32'h0;
    mem_wdata <= 32'hcafe_0f0f;
    mem_drive <= 1'b1;
    cyc(2);
    chk(d_oe, 32'hffff_ffff, "mem oe");
    chk(d_out, 32'hcafe_0f0f, "mem out");
    @(posedge mclk);
    mem_drive <= 1'b0;
    av(1'b1, 5'h04, 32'h1);
    @(posedge mclk);
    hold_n <= 1'b0;
    cyc(5);
    chk(clk_oe, 2'h2, "clk float");
    rchk(5'h18, 32'h3, "status hold");
    av(1'b1, 5'h08, 32'h1);
    cyc(2);
    chk(clk_oe, 2'h0, "clk float both");
    rchk(5'h08, 32'h1, "float second");
    results;
  end
endmodule // tb_parallel_port_data_pin_mux
